// ==== logic/pwm_sync_control.sv ====
/*
 * Synchronization and event-polarity control for four PWM controller
 * instances, with the control registers behind an AXI4-Lite slave.
 * Assumes the period and phase events come from the instance
 * counters on ref_clk, and that the asynchronous event inputs are pins.
 */
// The AXI4-Lite register port and the register offsets were decided locally.
// Summary of operation
// - phase-offset bit set: sync out from phase event, latch set on period event
// - phase-offset bit clear: sync out from period event, latch set on phase
// - period polarity bit inverts selected asynchronous period event inputs
// - duty polarity bit inverts selected asynchronous duty-cycle event inputs
// - bits 4 and 3 ignore writes and read as zero
// - source code 000 restarts period on own period event
// - codes 001 to 100 take sync in from instance one to four
// - every reset clears all implemented control bits to zero
`timescale 1ns/1ps
`default_nettype none
module pwm_sync_control
	import sync_ctl_pkg::*;
(
	input wire logic refClk,
	input wire logic rstn,
	// AXI4-Lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// per-instance timing events from the counters, one bit per instance
	input wire logic [3:0] periodEvt,
	input wire logic [3:0] phaseEvt,
	// asynchronous event pins
	input wire logic [3:0] asyncPeriodIn,
	input wire logic [3:0] asyncDutyIn,
	// outputs per instance
	output logic [3:0] syncOut,
	output logic [3:0] latchSet,
	output logic [3:0] periodRestart,
	output logic [3:0] asyncPeriodEvt,
	output logic [3:0] asyncDutyEvt
);
	logic [7:0] ctl_reg [NUM_INST];
	logic [3:0] perSync1_reg, perSync2_reg, dutySync1_reg, dutySync2_reg;
	logic awDone_reg, wDone_reg, bValid_reg, rValid_reg;
	logic [3:0] awAddr_reg;
	logic [7:0] wData_reg;
	logic wLane_reg;
	logic [31:0] rData_reg;
	logic [1:0] bResp_reg, rResp_reg;

	// write channel capture; address and data are taken in either order
	wire awTake = s_axi_awvalid && !awDone_reg && !bValid_reg;
	wire wTake = s_axi_wvalid && !wDone_reg && !bValid_reg;
	wire doWrite = awDone_reg && wDone_reg;
	wire [1:0] wIdx = awAddr_reg[3:2];
	wire wAligned = (awAddr_reg[1:0] == 2'h0);
	wire [1:0] rIdx = s_axi_araddr[3:2];
	wire rAligned = (s_axi_araddr[1:0] == 2'h0);
	wire arTake = s_axi_arvalid && !rValid_reg;
	// a register changes only on an aligned write whose low byte lane is strobed
	wire ctlWrite = doWrite && wAligned && wLane_reg;
	assign s_axi_awready = !awDone_reg && !bValid_reg;
	assign s_axi_wready = !wDone_reg && !bValid_reg;
	assign s_axi_arready = !rValid_reg;
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rdata = rData_reg;
	assign s_axi_rresp = rResp_reg;

	// write address/data holding and response
	always_ff @(posedge refClk)
	begin
		if (!rstn)
		begin
			awDone_reg <= 1'b0;
			wDone_reg <= 1'b0;
			bValid_reg <= 1'b0;
			awAddr_reg <= 4'h0;
			wData_reg <= 8'h00;
			wLane_reg <= 1'b0;
			bResp_reg <= RESP_OKAY;
		end
		else
		begin
			if (awTake)
			begin
				awDone_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (wTake)
			begin
				wDone_reg <= 1'b1;
				wData_reg <= s_axi_wdata[7:0];
				wLane_reg <= s_axi_wstrb[0];
			end
			if (doWrite)
			begin
				awDone_reg <= 1'b0;
				wDone_reg <= 1'b0;
				bValid_reg <= 1'b1;
				bResp_reg <= wAligned ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bValid_reg && s_axi_bready)
				bValid_reg <= 1'b0;
		end
	end

	// control registers; only bits 7..5 and 2..0 are stored
	always_ff @(posedge refClk)
	begin
		if (!rstn)
		begin
			for (int k = 0; k < NUM_INST; k++)
				ctl_reg[k] <= SYNC_CTL_RESET;
		end
		else if (ctlWrite)
			ctl_reg[wIdx] <= wData_reg & SYNC_CTL_MASK;
	end

	// the two-bit register index serves exactly four instances
	if (NUM_INST != 4)
	begin : g_inst_check
		$error("instance count must be four");
	end

	// read channel; unimplemented bits come back zero
	// a misaligned read answers with an error and zero data
	always_ff @(posedge refClk)
	begin
		if (!rstn)
		begin
			rValid_reg <= 1'b0;
			rData_reg <= 32'h0000_0000;
			rResp_reg <= RESP_OKAY;
		end
		else if (arTake)
		begin
			rValid_reg <= 1'b1;
			rData_reg <= rAligned ? {24'h00_0000, ctl_reg[rIdx] & SYNC_CTL_MASK} : 32'h0;
			rResp_reg <= rAligned ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rValid_reg && s_axi_rready)
			rValid_reg <= 1'b0;
	end

	// two-stage synchronisers for the asynchronous event pins
	// polarity is applied behind the second stage, so only settled values are inverted
	always_ff @(posedge refClk)
	begin
		if (!rstn)
		begin
			perSync1_reg <= 4'h0;
			perSync2_reg <= 4'h0;
			dutySync1_reg <= 4'h0;
			dutySync2_reg <= 4'h0;
		end
		else
		begin
			perSync1_reg <= asyncPeriodIn;
			perSync2_reg <= perSync1_reg;
			dutySync1_reg <= asyncDutyIn;
			dutySync2_reg <= dutySync1_reg;
		end
	end

	// per-instance event routing, all combinational; pin events come from the second synchroniser stage
	genvar gi;
	generate
		for (gi = 0; gi < NUM_INST; gi++)
		begin : g_route
			wire phaseOfs = ctl_reg[gi][PHASE_OFS_BIT];
			wire [2:0] srcSel = ctl_reg[gi][SRC_SEL_MSB:0];
			// the two events swap roles between sync out and latch set
			assign syncOut[gi] = phaseOfs ? phaseEvt[gi] : periodEvt[gi];
			assign latchSet[gi] = phaseOfs ? periodEvt[gi] : phaseEvt[gi];
			assign asyncPeriodEvt[gi] = perSync2_reg[gi] ^ ctl_reg[gi][PERIOD_INV_BIT];
			assign asyncDutyEvt[gi] = dutySync2_reg[gi] ^ ctl_reg[gi][DUTY_INV_BIT];
			// reserved codes 101 to 111 fall back to own period event
			assign periodRestart[gi] =
				(srcSel == SRC_INST1) ? syncOut[0] :
				(srcSel == SRC_INST2) ? syncOut[1] :
				(srcSel == SRC_INST3) ? syncOut[2] :
				(srcSel == SRC_INST4) ? syncOut[3] :
				periodEvt[gi];
		end
	endgenerate

	// checks kept beside the logic; instances two and three are watched, instance one also for the unstrobed write, all four for the pin reset; the
	// other two come out of the same generate loop
	// phase-offset bit: sync out and latch set trade their events
	sync_out_sel_a: assert property (@(posedge refClk) disable iff (!rstn)
		ctl_reg[1][7] |-> (syncOut[1] == phaseEvt[1] && latchSet[1] == periodEvt[1]))
		else $error("sync out not from phase event");
	phase_route_a: assert property (@(posedge refClk) disable iff (!rstn)
		ctl_reg[2][7] |-> (syncOut[2] == phaseEvt[2] && latchSet[2] == periodEvt[2]))
		else $error("third instance phase routing wrong");
	sync_out_per_a: assert property (@(posedge refClk) disable iff (!rstn)
		!ctl_reg[2][7] |-> (syncOut[2] == periodEvt[2] && latchSet[2] == phaseEvt[2]))
		else $error("sync out not from period event");
	period_route_a: assert property (@(posedge refClk) disable iff (!rstn)
		!ctl_reg[1][7] |-> (syncOut[1] == periodEvt[1] && latchSet[1] == phaseEvt[1]))
		else $error("second instance period routing wrong");

	// polarity: second stage equals the first stage one edge back, flipped by the bit;
	// the edge right after reset is skipped, as a one-edge reset may leave them apart
	period_pol_a: assert property (@(posedge refClk) disable iff (!rstn)
		$past(rstn) |-> asyncPeriodEvt[1] == ($past(perSync1_reg[1]) ^ ctl_reg[1][6]))
		else $error("period polarity wrong");
	period_flip_a: assert property (@(posedge refClk) disable iff (!rstn)
		$past(rstn) |-> asyncPeriodEvt[2] == ($past(perSync1_reg[2]) ^ ctl_reg[2][6]))
		else $error("third instance period polarity wrong");
	duty_pol_a: assert property (@(posedge refClk) disable iff (!rstn)
		$past(rstn) |-> asyncDutyEvt[2] == ($past(dutySync1_reg[2]) ^ ctl_reg[2][5]))
		else $error("duty polarity wrong");
	duty_flip_a: assert property (@(posedge refClk) disable iff (!rstn)
		$past(rstn) |-> asyncDutyEvt[1] == ($past(dutySync1_reg[1]) ^ ctl_reg[1][5]))
		else $error("second instance duty polarity wrong");

	// unimplemented bits stay zero in the store and on the read data
	unused_zero_a: assert property (@(posedge refClk) disable iff (!rstn)
		(s_axi_rvalid && s_axi_rresp == RESP_OKAY) |-> s_axi_rdata[4:3] == 2'h0)
		else $error("unimplemented bits read nonzero");
	unused_bits_a: assert property (@(posedge refClk) disable iff (!rstn)
		ctl_reg[1][4:3] == 2'h0 && ctl_reg[2][4:3] == 2'h0)
		else $error("unimplemented bits stored");

	// restart source: own period event, a peer's sync out, or its own sync out
	own_restart_a: assert property (@(posedge refClk) disable iff (!rstn)
		ctl_reg[1][2:0] == 3'h0 |-> periodRestart[1] == periodEvt[1])
		else $error("own period restart wrong");
	home_restart_a: assert property (@(posedge refClk) disable iff (!rstn)
		ctl_reg[2][2:0] == 3'h0 |-> periodRestart[2] == periodEvt[2])
		else $error("third instance own restart wrong");
	peer_restart_a: assert property (@(posedge refClk) disable iff (!rstn)
		ctl_reg[2][2:0] == 3'h4 |-> periodRestart[2] == syncOut[3])
		else $error("peer sync source wrong");
	peer_first_a: assert property (@(posedge refClk) disable iff (!rstn)
		ctl_reg[1][2:0] == 3'h1 |-> periodRestart[1] == syncOut[0])
		else $error("first peer sync source wrong");
	self_loop_a: assert property (@(posedge refClk) disable iff (!rstn)
		ctl_reg[1][2:0] == 3'h2 |-> periodRestart[1] == syncOut[1])
		else $error("self loop wrong");
	loop_back_a: assert property (@(posedge refClk) disable iff (!rstn)
		ctl_reg[2][2:0] == 3'h3 |-> periodRestart[2] == syncOut[2])
		else $error("third instance self loop wrong");

	// reset clears the store, the bus answers and the synchronised pins
	reset_clear_a: assert property (@(posedge refClk)
		!rstn |=> (ctl_reg[1] == 8'h00 && ctl_reg[2] == 8'h00))
		else $error("control not cleared by reset");
	reset_idle_a: assert property (@(posedge refClk)
		!rstn |=> (!s_axi_bvalid && !s_axi_rvalid))
		else $error("bus answer left over after reset");
	pin_reset_a: assert property (@(posedge refClk)
		!rstn |=> (asyncPeriodEvt == 4'h0 && asyncDutyEvt == 4'h0))
		else $error("pin events not cleared by reset");

	// register bus: writes land only when aligned and strobed, answers follow
	write_land_a: assert property (@(posedge refClk) disable iff (!rstn)
		(ctlWrite && wIdx == 2'h2) |=> ctl_reg[2] == ($past(wData_reg) & SYNC_CTL_MASK))
		else $error("write did not land");
	bad_addr_a: assert property (@(posedge refClk) disable iff (!rstn)
		(doWrite && !wAligned) |=> $stable(ctl_reg[1]))
		else $error("misaligned write changed a register");
	strobe_skip_a: assert property (@(posedge refClk) disable iff (!rstn)
		(doWrite && !wLane_reg && wIdx == 2'h0) |=> $stable(ctl_reg[0]))
		else $error("unstrobed write changed a register");
	write_resp_a: assert property (@(posedge refClk) disable iff (!rstn)
		(awDone_reg && wDone_reg) |=> s_axi_bvalid)
		else $error("write response missing");
	bresp_ok_a: assert property (@(posedge refClk) disable iff (!rstn)
		(doWrite && wAligned) |=> s_axi_bresp == RESP_OKAY)
		else $error("aligned write not answered okay");
	bresp_err_a: assert property (@(posedge refClk) disable iff (!rstn)
		(doWrite && !wAligned) |=> s_axi_bresp == RESP_SLVERR)
		else $error("misaligned write not refused");
	read_resp_a: assert property (@(posedge refClk) disable iff (!rstn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read response missing");
	rresp_err_a: assert property (@(posedge refClk) disable iff (!rstn)
		(arTake && !rAligned) |=> (s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0))
		else $error("misaligned read not refused");
	bvalid_block_a: assert property (@(posedge refClk) disable iff (!rstn)
		s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
		else $error("write taken while response pending");
	ar_block_a: assert property (@(posedge refClk) disable iff (!rstn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule : pwm_sync_control
`default_nettype wire

// ==== logic/sync_ctl_pkg.sv ====
/*
 * Shared constants for the PWM synchronization control block: register
 * offsets, field positions, reset values and sync source codes.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
`default_nettype none
package sync_ctl_pkg;
	localparam int NUM_INST = 4;
	// register byte offsets, one control register per instance
	localparam logic [3:0] INST1_SYNC_OFS = 4'h0;
	localparam logic [3:0] INST2_SYNC_OFS = 4'h4;
	localparam logic [3:0] INST3_SYNC_OFS = 4'h8;
	localparam logic [3:0] INST4_SYNC_OFS = 4'hC;
	// field positions
	localparam int PHASE_OFS_BIT = 7;
	localparam int PERIOD_INV_BIT = 6;
	localparam int DUTY_INV_BIT = 5;
	localparam int SRC_SEL_MSB = 2;
	// writable bits and reset value
	localparam logic [7:0] SYNC_CTL_MASK = 8'hE7;
	localparam logic [7:0] SYNC_CTL_RESET = 8'h00;
	// sync source codes
	typedef enum logic [2:0] {
		SRC_OWN = 3'b000,
		SRC_INST1 = 3'b001,
		SRC_INST2 = 3'b010,
		SRC_INST3 = 3'b011,
		SRC_INST4 = 3'b100
	} sync_src_t;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sync_ctl_pkg
`default_nettype wire

// ==== verification/peer_evt_model.sv ====
/* peer instance counters: per-instance period and phase event pulses.
   assumes one clock shared with the control block. */
`timescale 1ns/1ps
`default_nettype none
module peer_evt_model
(
	input wire logic refClk,
	input wire logic rstn,
	output logic [3:0] periodEvt,
	output logic [3:0] phaseEvt
);
	logic [3:0] cnt_reg;
	// free-running count stands in for four unrelated period counters
	always_ff @(posedge refClk)
		cnt_reg <= !rstn ? 4'h0 : cnt_reg + 4'h1;
	// patterns differ per bit so period and phase events are told apart
	assign periodEvt = {cnt_reg[0], cnt_reg[1] ^ cnt_reg[2], cnt_reg[3], cnt_reg[1]};
	assign phaseEvt = {cnt_reg[2], cnt_reg[0] ^ cnt_reg[3], cnt_reg[1], ~cnt_reg[0]};
endmodule : peer_evt_model
`default_nettype wire

// ==== verification/pwm_sync_control_tb_top.sv ====
/* bench: control registers over AXI4-Lite, event routing and polarity.
   assumes the peer model drives the timing events. */
`timescale 1ns/1ps
`default_nettype none
module pwm_sync_control_tb_top
	import sync_ctl_pkg::*;
;
	logic refClk = 1'h0, rstn = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] asyncPeriodIn = 4'h0, asyncDutyIn = 4'h0, periodEvt, phaseEvt;
	logic [3:0] syncOut, latchSet, periodRestart, asyncPeriodEvt, asyncDutyEvt;
	logic [3:0] expSync, expLatch, expRestart;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0] ctl [4];
	int err_count = 0, checked = 0;
	// 10 MHz
	always #50 refClk = ~refClk;
	pwm_sync_control u_dut (.refClk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periodEvt, .phaseEvt,
		.asyncPeriodIn, .asyncDutyIn, .syncOut, .latchSet, .periodRestart,
		.asyncPeriodEvt, .asyncDutyEvt);
	peer_evt_model u_peer (.refClk, .rstn, .periodEvt, .phaseEvt);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_sim;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	// address and data offered together, each dropped once its ready is seen
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge refClk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 20 && !s_axi_bvalid; n++)
		begin
			@(posedge refClk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (n == 20) begin check("write response", 0, 1); end_sim(); end
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a);
		int n;
		@(posedge refClk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 20 && !s_axi_rvalid; n++)
		begin
			@(posedge refClk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (n == 20) begin check("read response", 0, 1); end_sim(); end
	endtask : axi_read
	// expected routing worked out from the shadow copy of the registers
	task automatic check_outputs;
		int i;
		@(negedge refClk);
		for (i = 0; i < 4; i++)
		begin
			expSync[i] = ctl[i][7] ? phaseEvt[i] : periodEvt[i];
			expLatch[i] = ctl[i][7] ? periodEvt[i] : phaseEvt[i];
		end
		for (i = 0; i < 4; i++)
			expRestart[i] = ctl[i][2:0] == 3'h0 ? periodEvt[i] : expSync[ctl[i][2:0] - 3'h1];
		check("syncOut", syncOut, expSync);
		check("latchSet", latchSet, expLatch);
		check("periodRestart", periodRestart, expRestart);
		check("asyncPeriodEvt", asyncPeriodEvt,
			asyncPeriodIn ^ {ctl[3][6], ctl[2][6], ctl[1][6], ctl[0][6]});
		check("asyncDutyEvt", asyncDutyEvt,
			asyncDutyIn ^ {ctl[3][5], ctl[2][5], ctl[1][5], ctl[0][5]});
	endtask : check_outputs
	initial
	begin
		int c, i;
		repeat (10) @(posedge refClk);
		rstn <= 1'h1;
		for (i = 0; i < 4; i++) begin axi_read(4'(4 * i)); check("reset value", rd, 0); end
		// every source code on every instance, self-selection included
		for (c = 0; c < 5; c++)
		begin
			for (i = 0; i < 4; i++)
			begin
				ctl[i] = {c[0] ^ i[0], c[1] ^ i[1], c[1] ^ i[0], 2'h0, 3'((c + i) % 5)};
				axi_write(4'(4 * i), {24'hFFFFFF, ctl[i] | 8'h18});
				check("write okay", rsp, RESP_OKAY);
				axi_read(4'(4 * i));
				check("control readback", rd, {24'h0, ctl[i]});
			end
			asyncPeriodIn <= 4'(c * 3 + 5);
			asyncDutyIn <= 4'(c * 7 + 2);
			repeat (3) @(posedge refClk);
			repeat (6) check_outputs();
		end
		// misaligned address must leave the register alone
		axi_write(4'h5, 32'h000000FF);
		check("misaligned response", rsp, RESP_SLVERR);
		axi_read(4'h4);
		check("register after misaligned write", rd, {24'h0, ctl[1]});
		axi_read(4'h5);
		check("misaligned read response", rsp, RESP_SLVERR);
		check("misaligned read data", rd, 0);
		// low byte lane not strobed: answered okay, register left alone
		s_axi_wstrb <= 4'h0;
		axi_write(4'h0, 32'h000000FF);
		s_axi_wstrb <= 4'hF;
		check("unstrobed write response", rsp, RESP_OKAY);
		axi_read(4'h0);
		check("register after unstrobed write", rd, {24'h0, ctl[0]});
		// reset in mid-run clears every register and the routing with it
		@(posedge refClk);
		rstn <= 1'h0;
		repeat (2) @(posedge refClk);
		rstn <= 1'h1;
		for (i = 0; i < 4; i++) ctl[i] = 8'h00;
		for (i = 0; i < 4; i++) begin axi_read(4'(4 * i)); check("value after reset", rd, 0); end
		repeat (4) check_outputs();
		end_sim();
	end
endmodule : pwm_sync_control_tb_top
`default_nettype wire
